// ### verilog/cfm_pkg.sv
// Constants, enumerations and carriers for the clock fault monitor.
package cfm_pkg;

  // Channel counts. Signal-loss channels are in0, in1, in2, ref, in3, in4
  // and the crystal; frequency channels are in0, in1, in2 and ref.
  localparam int NUM_LOS = 7;
  localparam int NUM_OOF = 4;
  localparam int NUM_LOOP = 3;
  localparam int NUM_STAT = 14;

  // Channel indices.
  localparam int CH_IN0 = 0;
  localparam int CH_REF = 3;
  localparam int CH_XTAL = 6;

  // Field positions inside the status vectors.
  localparam int STAT_LOS_LSB = 0;
  localparam int STAT_XTAL_BIT = 6;
  localparam int STAT_OOF_LSB = 7;
  localparam int STAT_LOL_LSB = 11;

  // Field widths.
  localparam int PERIOD_W = 16;
  localparam int SENS_W = 4;
  localparam int WIN_W = 24;
  localparam int LIM_W = 13;
  localparam int PPM_W = 17;
  localparam int DLY_W = 24;
  localparam int WIDE_W = 48;

  // Precision limit in 1/16 ppm steps: 500 ppm is 8000 steps.
  localparam logic [LIM_W-1:0] OOF_LIMIT_MAX = 13'h1F40;
  // Lock thresholds in 0.1 ppm steps: 0.1 ppm up to 10,000 ppm.
  localparam logic [PPM_W-1:0] LOL_THR_MIN = 17'h00001;
  localparam logic [PPM_W-1:0] LOL_THR_MAX = 17'h186A0;
  // Fast monitor trips above 4000 ppm; the scale is parts per million.
  localparam logic [WIDE_W-1:0] FAST_OOF_PPM = 48'h000000000FA0;
  localparam logic [WIDE_W-1:0] PPM_SCALE = 48'h0000000F4240;
  // The fast window is the precise window divided by 2**FAST_WIN_SHIFT.
  localparam int FAST_WIN_SHIFT = 4;

  // Reset values: every loop starts out of lock, everything else clear.
  localparam logic [NUM_STAT-1:0] STAT_LIVE_RESET = 14'h3800;
  localparam logic [NUM_STAT-1:0] STAT_STICKY_RESET = 14'h0000;
  localparam logic [NUM_LOOP-1:0] LOL_RESET = 3'h7;

  // Choice of the zero-ppm reference for the frequency monitors.
  typedef enum logic [2:0] {
    REF_SEL_REF = 3'b000,
    REF_SEL_IN0 = 3'b001,
    REF_SEL_IN1 = 3'b010,
    REF_SEL_IN2 = 3'b011,
    REF_SEL_XTAL = 3'b100
  } cfm_ref_sel_e;

  // Static configuration held by the surrounding control logic.
  typedef struct packed {
    logic [NUM_LOS-1:0][PERIOD_W-1:0] los_max_period;
    logic [NUM_LOS-1:0][PERIOD_W-1:0] los_min_period;
    logic [NUM_LOS-1:0][SENS_W-1:0] los_sensitivity;
    logic xtal_los_keep_outputs;
    cfm_ref_sel_e oof_ref_sel;
    logic [NUM_OOF-1:0] prec_en;
    logic [NUM_OOF-1:0] fast_en;
    logic [WIN_W-1:0] prec_window;
    logic [NUM_OOF-1:0][WIN_W-1:0] oof_expected;
    logic [LIM_W-1:0] oof_limit;
    logic [LIM_W-1:0] oof_hyst;
    logic [NUM_LOOP-1:0][PPM_W-1:0] lock_loss_set_monitor_thr;
    logic [NUM_LOOP-1:0][PPM_W-1:0] lol_clr_thr;
    logic [NUM_LOOP-1:0][DLY_W-1:0] lol_clr_delay;
    logic [NUM_STAT-1:0] irq_mask;
  } cfm_cfg_s;

  // Live and sticky status as seen by software.
  typedef struct packed {
    logic [NUM_STAT-1:0] live;
    logic [NUM_STAT-1:0] sticky;
  } cfm_status_s;

endpackage

// ### verilog/cfm_monitor.sv
// Clock fault monitor: signal loss, frequency deviation, lock loss, irq.
`timescale 1ns/1ps

// Notes on behaviour
// - Time every input period to find missing edges.
// - Per-input sensitivity tolerates a number of errors.
// - Crystal signal loss disables all outputs by default.
// - Option keeps outputs running during crystal loss.
// - Zero-ppm reference selectable: ref, an input, crystal.
// - Deviation combines precise and fast monitors, each disabled.
// - Deviation live shows now; sticky holds until cleared.
// - Precise monitor 1/16 ppm, limit up to 500 ppm.
// - Precise monitor has hysteresis between assert and deassert.
// - Fast monitor trips beyond 4000 ppm either way.
// - Each loop has its own lock-loss monitor.
// - Active-low lock-loss pin per loop and reference.
// - Separate set and clear thresholds, 0.1-10,000 ppm.
// - Optional timer delays clearing of lock loss.
// - Lock-loss live shows now; sticky holds until cleared.
// - Interrupt pin asserts on any unmasked status change.
// - Each indicator has its own interrupt mask.
// - Interrupt releases only when sticky bits are cleared.
// - Four inputs get both checks; in3, in4 loss only.
module cfm_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [5:0] clk_in_i,
  input wire logic crystal_clock_input_i,
  input wire cfm_pkg::cfm_cfg_s cfg_i,
  input wire logic [cfm_pkg::NUM_LOOP-1:0][cfm_pkg::PPM_W-1:0] loop_freq_diff_i,
  input wire logic [cfm_pkg::NUM_STAT-1:0] sticky_clear_i,
  output cfm_pkg::cfm_status_s status_o,
  output logic crystal_signal_loss_alarm_o,
  output logic outputs_enable_o,
  output logic lock_loss_pin_loop_a_n_o,
  output logic lock_loss_pin_loop_c_n_o,
  output logic lock_loss_pin_loop_d_n_o,
  output logic lock_loss_pin_n_o,
  output logic interrupt_request_pin_n_o
);

  localparam int LW = cfm_pkg::NUM_LOS;
  localparam int OW = cfm_pkg::NUM_OOF;
  localparam int PW = cfm_pkg::NUM_LOOP;
  localparam int WW = cfm_pkg::WIN_W;

  // Magnitude of the difference between a count and its expected value.
  function automatic logic [cfm_pkg::WIN_W-1:0] abs_diff(
    input logic [cfm_pkg::WIN_W-1:0] a,
    input logic [cfm_pkg::WIN_W-1:0] b
  );
    abs_diff = (a >= b) ? (a - b) : (b - a);
  endfunction

  logic [LW-1:0] raw;
  logic [LW-1:0] sync_a;
  logic [LW-1:0] sync_b;
  logic [LW-1:0] sync_c;
  logic [LW-1:0] rise;
  logic [LW-1:0][cfm_pkg::PERIOD_W-1:0] period_cnt;
  logic [LW-1:0][cfm_pkg::SENS_W-1:0] err_cnt;
  logic [LW-1:0] period_bad;
  logic [LW-1:0] period_good;
  logic [LW-1:0] signal_loss_flag;
  logic ref_rise;
  logic [WW-1:0] prec_ref_cnt;
  logic [WW-1:0] fast_ref_cnt;
  logic [WW-1:0] fast_window;
  logic prec_end;
  logic fast_end;
  logic [OW-1:0][WW-1:0] prec_cnt;
  logic [OW-1:0][WW-1:0] fast_cnt;
  logic [cfm_pkg::LIM_W-1:0] lim_on;
  logic [cfm_pkg::LIM_W-1:0] lim_off;
  logic [OW-1:0] prec_oof;
  logic [OW-1:0] fast_oof;
  logic [OW-1:0] frequency_deviation_flag;
  logic [PW-1:0] lock_loss_flag;
  logic [PW-1:0][cfm_pkg::DLY_W-1:0] clr_timer;
  logic [cfm_pkg::NUM_STAT-1:0] next_live;
  logic [cfm_pkg::NUM_STAT-1:0] next_sticky;

  // Pins come from foreign clocks. The first flop feeds only the second;
  // the edge detector compares the second and third.
  assign raw = {crystal_clock_input_i, clk_in_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_c <= '0;
    end else begin
      sync_a <= raw;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  assign rise = sync_b & ~sync_c;

  // A period that ends too soon is a phase irregularity, and one that runs
  // past its maximum is a missing edge. Monitored clocks must stay below
  // half the system clock rate to be seen at all.
  always_comb begin
    for (int i = 0; i < LW; i++) begin
      period_good[i] = rise[i] &&
        (period_cnt[i] >= cfg_i.los_min_period[i]);
      period_bad[i] = (rise[i] &&
        (period_cnt[i] < cfg_i.los_min_period[i])) ||
        (!rise[i] && (period_cnt[i] >= cfg_i.los_max_period[i]));
    end
  end

  // Period timers restart on every edge and after every missed period.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_cnt <= '0;
    end else begin
      for (int i = 0; i < LW; i++) begin
        if (rise[i] || period_bad[i]) begin
          period_cnt[i] <= cfm_pkg::PERIOD_W'(1);
        end else begin
          period_cnt[i] <= period_cnt[i] + cfm_pkg::PERIOD_W'(1);
        end
      end
    end
  end

  // Errors accumulate until the channel's sensitivity is exceeded; one good
  // period forgives them, so an isolated glitch raises the flag only when the sensitivity is zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_cnt <= '0;
      signal_loss_flag <= '0;
    end else begin
      for (int i = 0; i < LW; i++) begin
        if (period_good[i]) begin
          err_cnt[i] <= '0;
          signal_loss_flag[i] <= 1'b0;
        end else if (period_bad[i]) begin
          if (err_cnt[i] >= cfg_i.los_sensitivity[i]) begin
            signal_loss_flag[i] <= 1'b1;
          end else begin
            err_cnt[i] <= err_cnt[i] + cfm_pkg::SENS_W'(1);
          end
        end
      end
    end
  end

  // Zero-ppm reference choice. If the chosen reference dies, windows stop
  // closing and the frequency verdicts hold their last value.
  always_comb begin
    unique case (cfg_i.oof_ref_sel)
      cfm_pkg::REF_SEL_REF: ref_rise = rise[cfm_pkg::CH_REF];
      cfm_pkg::REF_SEL_IN0: ref_rise = rise[cfm_pkg::CH_IN0];
      cfm_pkg::REF_SEL_IN1: ref_rise = rise[cfm_pkg::CH_IN0 + 1];
      cfm_pkg::REF_SEL_IN2: ref_rise = rise[cfm_pkg::CH_IN0 + 2];
      cfm_pkg::REF_SEL_XTAL: ref_rise = rise[cfm_pkg::CH_XTAL];
      default: ref_rise = rise[cfm_pkg::CH_REF];
    endcase
  end

  // The precise window is long enough that one count is 1/16 ppm; the fast
  // window is a fraction of it, trading accuracy for reaction time.
  assign fast_window = cfg_i.prec_window >> cfm_pkg::FAST_WIN_SHIFT;
  assign prec_end = ref_rise &&
    (prec_ref_cnt + WW'(1) >= cfg_i.prec_window);
  assign fast_end = ref_rise && (fast_ref_cnt + WW'(1) >= fast_window);

  // Reference edge counters that frame both measurement windows.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prec_ref_cnt <= '0;
      fast_ref_cnt <= '0;
    end else begin
      if (prec_end) begin
        prec_ref_cnt <= '0;
      end else if (ref_rise) begin
        prec_ref_cnt <= prec_ref_cnt + WW'(1);
      end
      if (fast_end) begin
        fast_ref_cnt <= '0;
      end else if (ref_rise) begin
        fast_ref_cnt <= fast_ref_cnt + WW'(1);
      end
    end
  end

  // Edge counts of the four measured inputs. An edge in the closing cycle
  // opens the next window so that no edge is dropped.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prec_cnt <= '0;
      fast_cnt <= '0;
    end else begin
      for (int j = 0; j < OW; j++) begin
        if (prec_end) begin
          prec_cnt[j] <= WW'(rise[j]);
        end else if (rise[j]) begin
          prec_cnt[j] <= prec_cnt[j] + WW'(1);
        end
        if (fast_end) begin
          fast_cnt[j] <= WW'(rise[j]);
        end else if (rise[j]) begin
          fast_cnt[j] <= fast_cnt[j] + WW'(1);
        end
      end
    end
  end

  // Limit clamped to 500 ppm; the release level sits one hysteresis lower.
  assign lim_on = (cfg_i.oof_limit > cfm_pkg::OOF_LIMIT_MAX) ?
    cfm_pkg::OOF_LIMIT_MAX : cfg_i.oof_limit;
  assign lim_off = (lim_on > cfg_i.oof_hyst) ?
    (lim_on - cfg_i.oof_hyst) : '0;

  // Precise verdict with hysteresis, judged once per window.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prec_oof <= '0;
    end else if (prec_end) begin
      for (int j = 0; j < OW; j++) begin
        if (abs_diff(prec_cnt[j], cfg_i.oof_expected[j]) >
            WW'(lim_on)) begin
          prec_oof[j] <= 1'b1;
        end else if (abs_diff(prec_cnt[j], cfg_i.oof_expected[j]) <=
                     WW'(lim_off)) begin
          prec_oof[j] <= 1'b0;
        end
      end
    end
  end

  // Fast verdict: deviation times a million against expected times 4000.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_oof <= '0;
    end else if (fast_end) begin
      for (int j = 0; j < OW; j++) begin
        fast_oof[j] <= (cfm_pkg::WIDE_W'(abs_diff(fast_cnt[j],
          cfg_i.oof_expected[j] >> cfm_pkg::FAST_WIN_SHIFT)) *
          cfm_pkg::PPM_SCALE) >
          (cfm_pkg::WIDE_W'(cfg_i.oof_expected[j] >>
          cfm_pkg::FAST_WIN_SHIFT) * cfm_pkg::FAST_OOF_PPM);
      end
    end
  end

  // Either monitor may be switched off on its own.
  assign frequency_deviation_flag = (prec_oof & cfg_i.prec_en) |
    (fast_oof & cfg_i.fast_en);

  // Lock loss per loop: the set threshold raises it at once, the clear
  // threshold must hold for the whole delay before it drops. A zero delay
  // clears on the first cycle below the clear threshold.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_loss_flag <= cfm_pkg::LOL_RESET;
      clr_timer <= '0;
    end else begin
      for (int k = 0; k < PW; k++) begin
        if (loop_freq_diff_i[k] > ((cfg_i.lock_loss_set_monitor_thr[k] <
            cfm_pkg::LOL_THR_MIN) ? cfm_pkg::LOL_THR_MIN :
            (cfg_i.lock_loss_set_monitor_thr[k] > cfm_pkg::LOL_THR_MAX) ?
            cfm_pkg::LOL_THR_MAX : cfg_i.lock_loss_set_monitor_thr[k])) begin
          lock_loss_flag[k] <= 1'b1;
          clr_timer[k] <= '0;
        end else if (lock_loss_flag[k] && loop_freq_diff_i[k] <
                     ((cfg_i.lol_clr_thr[k] < cfm_pkg::LOL_THR_MIN) ?
                     cfm_pkg::LOL_THR_MIN : (cfg_i.lol_clr_thr[k] >
                     cfm_pkg::LOL_THR_MAX) ? cfm_pkg::LOL_THR_MAX :
                     cfg_i.lol_clr_thr[k])) begin
          if (clr_timer[k] >= cfg_i.lol_clr_delay[k]) begin
            lock_loss_flag[k] <= 1'b0;
            clr_timer[k] <= '0;
          end else begin
            clr_timer[k] <= clr_timer[k] + cfm_pkg::DLY_W'(1);
          end
        end else begin
          clr_timer[k] <= '0;
        end
      end
    end
  end

  // Live vector in status bit order: loss, deviation, lock loss.
  assign next_live = {lock_loss_flag, frequency_deviation_flag,
    signal_loss_flag};

  // Every edge of a live bit latches its sticky bit. A fresh event wins over
  // a clear written in the same cycle, so no change is ever lost.
  assign next_sticky = (status_o.sticky & ~sticky_clear_i) |
    (next_live ^ status_o.live);

  // Status registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_o.live <= cfm_pkg::STAT_LIVE_RESET;
      status_o.sticky <= cfm_pkg::STAT_STICKY_RESET;
    end else begin
      status_o.live <= next_live;
      status_o.sticky <= next_sticky;
    end
  end

  // Interrupt follows the unmasked sticky bits, so only clearing them
  // releases the pin.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interrupt_request_pin_n_o <= 1'b1;
    end else begin
      interrupt_request_pin_n_o <=
        ~|(next_sticky & ~cfg_i.irq_mask);
    end
  end

  // Pins and output gating. The reference pin shows loss or deviation of
  // the reference input, since the reference has no loop of its own.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_loss_pin_loop_a_n_o <= 1'b0;
      lock_loss_pin_loop_c_n_o <= 1'b0;
      lock_loss_pin_loop_d_n_o <= 1'b0;
      lock_loss_pin_n_o <= 1'b1;
      crystal_signal_loss_alarm_o <= 1'b0;
      outputs_enable_o <= 1'b1;
    end else begin
      lock_loss_pin_loop_a_n_o <= ~lock_loss_flag[0];
      lock_loss_pin_loop_c_n_o <= ~lock_loss_flag[1];
      lock_loss_pin_loop_d_n_o <= ~lock_loss_flag[2];
      lock_loss_pin_n_o <= ~(signal_loss_flag[cfm_pkg::CH_REF] |
        frequency_deviation_flag[cfm_pkg::CH_REF]);
      crystal_signal_loss_alarm_o <= signal_loss_flag[cfm_pkg::CH_XTAL];
      outputs_enable_o <= ~(signal_loss_flag[cfm_pkg::CH_XTAL] &
        ~cfg_i.xtal_los_keep_outputs);
    end
  end

endmodule

// ### testbench/cfm_monitor_asserts.sv
// Port checker for the clock fault monitor, bound into the design.
`timescale 1ns/1ps
module cfm_monitor_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [5:0] clk_in_i,
  input wire logic crystal_clock_input_i,
  input wire cfm_pkg::cfm_cfg_s cfg_i,
  input wire logic [2:0][16:0] loop_freq_diff_i,
  input wire logic [13:0] sticky_clear_i,
  input wire cfm_pkg::cfm_status_s status_o,
  input wire logic crystal_signal_loss_alarm_o,
  input wire logic outputs_enable_o,
  input wire logic lock_loss_pin_loop_a_n_o,
  input wire logic lock_loss_pin_loop_c_n_o,
  input wire logic lock_loss_pin_loop_d_n_o,
  input wire logic lock_loss_pin_n_o,
  input wire logic interrupt_request_pin_n_o
);
  logic [24:0] below;
  logic [13:0] hot;

  // Cycles loop A has stayed below its clear threshold, saturating.
  always_ff @(posedge clk_i) begin
    if (rst_i || loop_freq_diff_i[0] >= cfg_i.lol_clr_thr[0]) begin
      below <= 25'h0000000;
    end else if (!below[24]) begin
      below <= below + 25'h0000001;
    end
  end

  // Unmasked sticky bits that no clear pulse is removing.
  assign hot = status_o.sticky & ~cfg_i.irq_mask & ~sticky_clear_i;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Loop pins are the inverse of the live lock-loss bits.
  loop_pins_a: assert property (
    {lock_loss_pin_loop_d_n_o, lock_loss_pin_loop_c_n_o,
     lock_loss_pin_loop_a_n_o} == ~status_o.live[13:11])
    else $error("loop pin differs from live bit");
  ref_pin_a: assert property (
    lock_loss_pin_n_o == !(status_o.live[3] || status_o.live[10]))
    else $error("reference pin wrong");
  xtal_off_a: assert property (
    (crystal_signal_loss_alarm_o && !cfg_i.xtal_los_keep_outputs) [*2]
    |-> !outputs_enable_o) else $error("outputs left on");
  xtal_keep_a: assert property (
    (!crystal_signal_loss_alarm_o || cfg_i.xtal_los_keep_outputs) [*2]
    |-> outputs_enable_o) else $error("outputs wrongly off");
  sticky_set_a: assert property (
    ((status_o.live ^ $past(status_o.live)) & ~status_o.sticky) == 14'h0)
    else $error("live change not latched");
  sticky_hold_a: assert property (
    ($past(status_o.sticky) & ~$past(sticky_clear_i) & ~status_o.sticky)
    == 14'h0) else $error("sticky bit lost");
  irq_raise_a: assert property (
    (|hot) |=> !interrupt_request_pin_n_o) else $error("irq not raised");
  irq_quiet_a: assert property (
    !(|(status_o.sticky & ~cfg_i.irq_mask)) |-> interrupt_request_pin_n_o)
    else $error("irq without unmasked sticky");
  lol_hold_a: assert property (
    $fell(status_o.live[11]) |-> below > cfg_i.lol_clr_delay[0])
    else $error("lock loss cleared early");
  // Each loop has its own set monitor. The set level never drops below its
  // clamped minimum of one step, so a smaller difference proves nothing.
  for (genvar k = 0; k < 3; k++) begin : lp
    lock_loss_set_monitor_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      loop_freq_diff_i[k] > cfg_i.lock_loss_set_monitor_thr[k] &&
      loop_freq_diff_i[k] > 17'h00001 |-> ##2 status_o.live[11+k])
      else $error("lock loss not set");
  end
endmodule

bind cfm_monitor cfm_monitor_asserts cfm_monitor_asserts_i (
  .clk_i(clk_i), .rst_i(rst_i), .clk_in_i(clk_in_i),
  .crystal_clock_input_i(crystal_clock_input_i), .cfg_i(cfg_i),
  .loop_freq_diff_i(loop_freq_diff_i), .sticky_clear_i(sticky_clear_i),
  .status_o(status_o),
  .crystal_signal_loss_alarm_o(crystal_signal_loss_alarm_o),
  .outputs_enable_o(outputs_enable_o),
  .lock_loss_pin_loop_a_n_o(lock_loss_pin_loop_a_n_o),
  .lock_loss_pin_loop_c_n_o(lock_loss_pin_loop_c_n_o),
  .lock_loss_pin_loop_d_n_o(lock_loss_pin_loop_d_n_o),
  .lock_loss_pin_n_o(lock_loss_pin_n_o),
  .interrupt_request_pin_n_o(interrupt_request_pin_n_o));

// ### testbench/cfm_clk_src.sv
// Clock source model: six input pins and the crystal.
`timescale 1ns/1ps
module cfm_clk_src (
  input wire logic [6:0] run_i,
  input wire logic [6:0][7:0] half_ns_i,
  output logic [5:0] clk_in_o,
  output logic crystal_o
);
  for (genvar g = 0; g < 7; g++) begin : src
    logic lvl;
    // A stopped source stands still, as a dead oscillator does.
    initial begin
      lvl = 1'b0;
      forever begin
        #(half_ns_i[g]);
        if (run_i[g]) begin
          lvl = ~lvl;
        end
      end
    end
    if (g < 6) begin : pin
      assign clk_in_o[g] = lvl;
    end else begin : xt
      assign crystal_o = lvl;
    end
  end
endmodule

// ### testbench/tb_cfm_monitor.sv
// Self-checking bench for the clock fault monitor.
`timescale 1ns/1ps
module tb_cfm_monitor;
  logic clk_i;
  logic rst_i;
  logic [5:0] pins;
  logic xtal;
  cfm_pkg::cfm_cfg_s cfg;
  logic [2:0][16:0] diff;
  logic [13:0] clr;
  cfm_pkg::cfm_status_s st;
  logic alarm, oen, pa_n, pc_n, pd_n, pref_n, irq_n;
  logic [6:0] run;
  logic [6:0][7:0] half;
  int fail_count;
  int n_tests;
  int cycles;

  cfm_monitor cfm_monitor_i (.clk_i(clk_i), .rst_i(rst_i), .clk_in_i(pins),
    .crystal_clock_input_i(xtal), .cfg_i(cfg), .loop_freq_diff_i(diff),
    .sticky_clear_i(clr), .status_o(st),
    .crystal_signal_loss_alarm_o(alarm), .outputs_enable_o(oen),
    .lock_loss_pin_loop_a_n_o(pa_n), .lock_loss_pin_loop_c_n_o(pc_n),
    .lock_loss_pin_loop_d_n_o(pd_n), .lock_loss_pin_n_o(pref_n),
    .interrupt_request_pin_n_o(irq_n));
  cfm_clk_src cfm_clk_src_i (.run_i(run), .half_ns_i(half),
    .clk_in_o(pins), .crystal_o(xtal));

  // Clock at 40 MHz.
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // A hung scenario is cut short and counted as a mismatch.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Inputs move a fixed 2 ns after the rising edge.
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask

  task automatic wait_live(input int idx, input logic v, input int lim);
    for (int k = 0; k < lim && st.live[idx] !== v; k++) begin
      step(1);
    end
  endtask

  // One write-one-to-clear pulse on every sticky bit.
  task automatic clear_all();
    clr = 14'h3FFF;
    step(1);
    clr = 14'h0000;
  endtask

  task automatic t_reset();
    check(st.live, cfm_pkg::STAT_LIVE_RESET);
    check(st.sticky, 14'h0000);
    check({pd_n, pc_n, pa_n, pref_n, irq_n, alarm, oen}, 7'h0D);
  endtask

  task automatic t_lock();
    step(300);
    check(st.live, 14'h0000);
    check(st.sticky[13:11], 3'h7);
    clear_all();
    check(st.sticky, 14'h0000);
    check(irq_n, 1'b1);
    diff[0] = 17'h00064;
    diff[1] = 17'h00065;
    step(3);
    check({st.live[12:11], pc_n, pa_n}, 4'h9);
    check(st.sticky[12], 1'b1);
    step(1);
    check(irq_n, 1'b0);
    diff[1] = 17'h00009;
    step(5);
    check(st.live[12], 1'b1);
    wait_live(12, 1'b0, 6);
    check(st.live[12], 1'b0);
    diff = '0;
    clear_all();
    check(irq_n, 1'b1);
  endtask

  task automatic t_los();
    run[0] = 1'b0;
    step(48);
    check({st.live[0], st.sticky[0], irq_n}, 3'h7);
    run[4:3] = 2'h0;
    step(12);
    check(st.live[0], 1'b1);
    step(12);
    check({st.live[4:3], pref_n, irq_n}, 4'hC);
    run = 7'h7F;
    wait_live(0, 1'b0, 60);
    check({st.live[0], st.sticky[0]}, 2'h1);
    step(400);
    clear_all();
    check(irq_n, 1'b1);
  endtask

  task automatic t_xtal();
    run[6] = 1'b0;
    wait_live(6, 1'b1, 60);
    step(2);
    check({alarm, oen}, 2'h2);
    cfg.xtal_los_keep_outputs = 1'b1;
    step(3);
    check({alarm, oen}, 2'h3);
    run[6] = 1'b1;
    cfg.xtal_los_keep_outputs = 1'b0;
    wait_live(6, 1'b0, 60);
    check(oen, 1'b1);
  endtask

  task automatic t_oof();
    half[1] = 8'h50;
    wait_live(8, 1'b1, 400);
    check(st.live[8:7], 2'h2);
    cfg.prec_en = 4'hD;
    wait_live(8, 1'b0, 400);
    check(st.live[8], 1'b0);
    cfg.prec_en = 4'hF;
    cfg.oof_ref_sel = cfm_pkg::REF_SEL_IN1;
    wait_live(10, 1'b1, 400);
    check({st.live[10], pref_n}, 2'h2);
    wait_live(8, 1'b0, 400);
    check(st.live[8], 1'b0);
  endtask

  // Fast monitor alone, with the crystal as the zero-ppm reference. An input
  // a quarter fast must trip it; back on frequency it must stay quiet.
  task automatic t_fast();
    cfg.prec_en = 4'h0;
    cfg.fast_en = 4'h2;
    cfg.oof_ref_sel = cfm_pkg::REF_SEL_XTAL;
    wait_live(8, 1'b1, 100);
    check({st.live[10:7], pref_n}, 5'h05);
    half[1] = 8'h64;
    step(60);
    check(st.live[8], 1'b0);
  endtask

  // Static setup, reset for ten cycles, then every scenario in turn.
  initial begin
    fail_count = 0;
    n_tests = 0;
    cycles = 0;
    rst_i = 1'b1;
    run = 7'h7F;
    half = {7{8'h64}};
    clr = 14'h0000;
    diff = '0;
    cfg = '0;
    for (int i = 0; i < 7; i++) begin
      cfg.los_max_period[i] = 16'h0010;
      cfg.los_min_period[i] = 16'h0004;
    end
    cfg.los_sensitivity[0] = 4'h1;
    cfg.oof_ref_sel = cfm_pkg::REF_SEL_REF;
    cfg.prec_en = 4'hF;
    cfg.prec_window = 24'h000010;
    for (int j = 0; j < 4; j++) begin
      cfg.oof_expected[j] = 24'h000010;
    end
    cfg.oof_limit = 13'h0002;
    cfg.oof_hyst = 13'h0001;
    for (int k = 0; k < 3; k++) begin
      cfg.lock_loss_set_monitor_thr[k] = 17'h00064;
      cfg.lol_clr_thr[k] = 17'h0000A;
      cfg.lol_clr_delay[k] = 24'h000005;
    end
    cfg.irq_mask = 14'h0001;
    step(10);
    t_reset();
    rst_i = 1'b0;
    t_lock();
    t_los();
    t_xtal();
    t_oof();
    t_fast();
    conclude();
  end
endmodule
